/* File: rtl/error_queue_status_logger.v */
// error queue, event status flags and output-board self-test coding
// assumes an AXI4-Lite master on the system clock; error events are one-cycle pulses
// assumes error pulses and self-test levels are synchronous to i_clk
//
// What this block does
// R1 - a command error sets event status bit five and is queued
// R2 - an execution error sets event status bit four and is queued
// R3 - a query error sets event status bit two and is queued
// R4 - a device-dependent error sets its event status flag and is queued
// R5 - queue holds ten entries of all four error classes, read by the error query
// R6 - an error into a full queue overwrites entry ten with code -350
// R7 - an invalid or misplaced command queues code -100
// R8 - an invalid numeric argument queues code -120
// R9 - an invalid non-numeric argument queues code -130
// R10 - failed settings transfer or level conflict queues code -200
// R11 - a parameter out of range queues code -212
// R12 - an unspecified query fault queues code -400
// R13 - self-test reports output-board failures 300..313, channel two adds 100
// R14 - codes 300..303 and 310..313 flag hybrid levels, fast and slow slope
// R15 - codes 304..309 flag the six SMD board failures in order
// R16 - queue reads oldest first, removing it; empty queue reads code 0
// R17 - the device-dependent flag sits at event status bit three
`timescale 1ns/10ps
`default_nettype none
`include "err_log_defs.vh"

module error_queue_status_logger #(
  parameter DEPTH = `QUEUE_DEPTH
) (
  input wire i_clk,
  input wire i_reset_n,

  // error event pulses
  input wire i_cmd_invalid,
  input wire i_num_arg_bad,
  input wire i_nonnum_arg_bad,
  input wire i_exec_fail,
  input wire i_range_bad,
  input wire i_query_fault,
  input wire i_dev_error,
  input wire [15:0] i_dev_code,

  // self-test results: one failure bit per code 300..313, per channel
  input wire i_test_done,
  input wire [13:0] i_ch1_fail,
  input wire [13:0] i_ch2_fail,

  // axi4-lite slave
  input wire [5:0] i_awaddr,
  input wire i_awvalid,
  output reg o_awready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_wvalid,
  output reg o_wready,
  output reg [1:0] o_bresp,
  output reg o_bvalid,
  input wire i_bready,
  input wire [5:0] i_araddr,
  input wire i_arvalid,
  output reg o_arready,
  output reg [31:0] o_rdata,
  output reg [1:0] o_rresp,
  output reg o_rvalid,
  input wire i_rready,
  output reg o_irq
);

  // queue storage and its fill count
  reg [15:0] queue [0:DEPTH-1];
  reg [3:0] count;
  wire [7:0] esr;
  wire [2:0] int_status;
  reg [2:0] int_mask;
  reg [15:0] test_code;
  reg [15:0] next_test_code;
  reg [15:0] new_code;
  reg new_event;
  // write channel holding registers
  reg have_aw;
  reg have_w;
  reg [3:0] aw_idx;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  // combinational values
  reg [7:0] esr_set;
  reg [2:0] int_set;
  reg [31:0] next_rdata;
  reg [1:0] next_rresp;
  wire [15:0] ch1_code;
  wire [15:0] ch2_code;
  wire ch1_any;
  wire ch2_any;
  integer i;

  // one error per cycle; when several arrive together the fixed priority below
  // picks the queued code, but every class still raises its status flag
  always @* begin
    new_event = 1'b1;
    if (i_cmd_invalid)
      new_code = `CODE_CMD; // R7
    else if (i_num_arg_bad)
      new_code = `CODE_NUM_ARG; // R8
    else if (i_nonnum_arg_bad)
      new_code = `CODE_NONNUM_ARG; // R9
    else if (i_exec_fail)
      new_code = `CODE_EXEC; // R10
    else if (i_range_bad)
      new_code = `CODE_RANGE; // R11
    else if (i_query_fault)
      new_code = `CODE_QUERY; // R12
    else if (i_dev_error)
      new_code = i_dev_code;
    else begin
      new_code = `CODE_NONE;
      new_event = 1'b0;
    end
  end

  // lowest failing bit wins; bits 0..3 hybrid fast, 4..9 smd, 10..13 hybrid slow
  // each channel is encoded on its own; channel one wins when both fail
  fail_encoder #(
    .WIDTH(14),
    .BASE(`CODE_TEST_CH1)
  ) ch1_enc (
    .i_fail(i_ch1_fail),
    .o_any(ch1_any),
    .o_code(ch1_code)
  );

  fail_encoder #(
    .WIDTH(14),
    .BASE(`CODE_TEST_CH1 + `CODE_TEST_CH2_ADD)
  ) ch2_enc (
    .i_fail(i_ch2_fail),
    .o_any(ch2_any),
    .o_code(ch2_code)
  );

  always @* begin
    next_test_code = `CODE_NONE;
    if (ch1_any)
      next_test_code = ch1_code; // R13
    else if (ch2_any)
      next_test_code = ch2_code; // R13
  end

  wire wr_fire = have_aw && have_w && !o_bvalid;
  wire rd_fire = i_arvalid && o_arready;
  wire pop = rd_fire && (i_araddr[5:2] == `REG_QUEUE) && (count != 4'h0);
  wire wr_clear = wr_fire && w_strb[0];

  // a write without the low byte strobe still answers but changes nothing
  wire hit_esr = wr_clear && (aw_idx == `REG_ESR);
  wire hit_int_status = wr_clear && (aw_idx == `REG_INT_STATUS);
  wire hit_int_mask = wr_clear && (aw_idx == `REG_INT_MASK);
  wire wr_mapped = (aw_idx == `REG_ESR) || (aw_idx == `REG_INT_STATUS) ||
                   (aw_idx == `REG_INT_MASK);

  // an error into a full queue counts as a device-dependent fault as well
  wire queue_full = (count == DEPTH[3:0]);
  wire overflow = new_event && queue_full && !pop;
  wire cmd_class = i_cmd_invalid || i_num_arg_bad || i_nonnum_arg_bad;
  wire exec_class = i_exec_fail || i_range_bad;
  wire test_fail = ch1_any || ch2_any;

  // the pin lags the status by one cycle so that it comes from a flip-flop
  wire irq_level = |(int_status & int_mask);

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count <= 4'h0;
      for (i = 0; i < DEPTH; i = i + 1)
        queue[i] <= 16'h0000;
    end else begin
      // entries past count hold stale codes; the read mux gates them by count
      // pop shifts toward the head, push lands at the new tail
      if (pop) begin
        for (i = 0; i < DEPTH - 1; i = i + 1)
          queue[i] <= queue[i+1]; // R16
      end
      if (new_event) begin
        if (count == DEPTH[3:0] && !pop)
          queue[DEPTH-1] <= `CODE_OVERFLOW; // R6
        else if (pop)
          queue[count-4'h1] <= new_code; // R5
        else
          queue[count] <= new_code; // R5
      end
      // a pop and a push in one cycle cancel in the count, so no overflow
      if (pop && !new_event)
        count <= count - 4'h1;
      else if (!pop && new_event && count != DEPTH[3:0])
        count <= count + 4'h1;
    end
  end

  // status flags: set wins over a software write-one-to-clear in the same cycle
  always @* begin
    esr_set = 8'h00;
    esr_set[`ESR_CME] = cmd_class; // R1
    esr_set[`ESR_EXE] = exec_class; // R2
    esr_set[`ESR_QYE] = i_query_fault; // R3
    esr_set[`ESR_DDE] = i_dev_error || overflow; // R4 R17
    int_set = 3'h0;
    int_set[`INT_QUEUE_EVENT] = new_event;
    int_set[`INT_OVERFLOW] = overflow;
    int_set[`INT_TEST_FAIL] = i_test_done && test_fail;
  end

  sticky_flags #(
    .WIDTH(8)
  ) esr_flags (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_set(esr_set),
    .i_clear(hit_esr),
    .i_clear_bits(w_data[7:0]),
    .o_flags(esr)
  );

  sticky_flags #(
    .WIDTH(3)
  ) int_flags (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_set(int_set),
    .i_clear(hit_int_status),
    .i_clear_bits(w_data[2:0]),
    .o_flags(int_status)
  );

  // mask and the last self-test result
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      int_mask <= 3'h0;
      test_code <= 16'h0000;
    end else begin
      if (hit_int_mask)
        int_mask <= w_data[2:0];
      if (i_test_done)
        test_code <= next_test_code; // R13
    end
  end

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n)
      o_irq <= 1'b0;
    else
      o_irq <= irq_level;
  end

  // write channel: address and data taken independently, response after both
  // readies are registered and held high while idle, so a request is taken at its first edge
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      have_aw <= 1'b0;
      have_w <= 1'b0;
      aw_idx <= 4'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= 2'b00;
    end else begin
      o_awready <= !have_aw && !(i_awvalid && o_awready);
      o_wready <= !have_w && !(i_wvalid && o_wready);
      if (i_awvalid && o_awready) begin
        have_aw <= 1'b1;
        aw_idx <= i_awaddr[5:2];
      end
      if (i_wvalid && o_wready) begin
        have_w <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      if (wr_fire) begin
        have_aw <= 1'b0;
        have_w <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= wr_mapped ? 2'b00 : 2'b10;
      end else if (o_bvalid && i_bready)
        o_bvalid <= 1'b0;
    end
  end

  // read mux; unmapped offsets give zero data and slverr
  always @* begin
    next_rresp = 2'b00;
    case (i_araddr[5:2])
      `REG_ESR: next_rdata = {24'h000000, esr};
      `REG_QUEUE: next_rdata = (count == 4'h0) ? 32'h00000000 : // R16
                               {{16{queue[0][15]}}, queue[0]};
      `REG_COUNT: next_rdata = {28'h0000000, count};
      `REG_INT_STATUS: next_rdata = {29'h0, int_status};
      `REG_INT_MASK: next_rdata = {29'h0, int_mask};
      `REG_TEST_RESULT: next_rdata = {16'h0000, test_code};
      default: begin
        next_rdata = 32'h00000000;
        next_rresp = 2'b10;
      end
    endcase
  end

  // read channel; unmapped addresses answer slverr with zero data
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h00000000;
      o_rresp <= 2'b00;
    end else begin
      // arready stays low while an answer is pending: one read at a time
      o_arready <= !o_rvalid && !rd_fire;
      if (rd_fire) begin
        o_rvalid <= 1'b1;
        o_rresp <= next_rresp;
        o_rdata <= next_rdata;
      end else if (o_rvalid && i_rready)
        o_rvalid <= 1'b0;
    end
  end

endmodule

// lowest set failure bit of one channel as a self-test code
module fail_encoder #(
  parameter WIDTH = 14,
  parameter [15:0] BASE = 16'd300
) (
  input wire [WIDTH-1:0] i_fail,
  output reg o_any,
  output reg [15:0] o_code
);

  integer k;

  // scan from the top down so the lowest failing bit is left standing
  // failure bit k maps to code BASE plus k
  always @* begin
    o_any = 1'b0;
    o_code = 16'h0000;
    for (k = WIDTH - 1; k >= 0; k = k - 1) begin
      if (i_fail[k]) begin
        o_any = 1'b1;
        o_code = BASE + k[15:0]; // R13 R14 R15
      end
    end
  end

endmodule

// sticky flag bank: hardware sets, software writes ones to clear
module sticky_flags #(
  parameter WIDTH = 8
) (
  input wire i_clk,
  input wire i_reset_n,
  input wire [WIDTH-1:0] i_set,
  input wire i_clear,
  input wire [WIDTH-1:0] i_clear_bits,
  output reg [WIDTH-1:0] o_flags
);

  // a set arriving with the clear wins, so no event is lost to software
  // the clear only touches the bits written as one
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n)
      o_flags <= {WIDTH{1'b0}};
    else if (i_clear)
      o_flags <= (o_flags & ~i_clear_bits) | i_set;
    else
      o_flags <= o_flags | i_set;
  end

endmodule
`default_nettype wire

/* File: inc/err_log_defs.vh */
// error logger constants: register offsets, field positions, codes
// assumes inclusion by the single design file of the error logger
`ifndef ERR_LOG_DEFS_VH
`define ERR_LOG_DEFS_VH

`define REG_ESR 4'h0
`define REG_QUEUE 4'h1
`define REG_COUNT 4'h2
`define REG_INT_STATUS 4'h3
`define REG_INT_MASK 4'h4
`define REG_TEST_RESULT 4'h5
`define REG_TEST_CTRL 4'h6

`define ESR_QYE 2
`define ESR_DDE 3
`define ESR_EXE 4
`define ESR_CME 5

`define CODE_NONE 16'sh0000
`define CODE_CMD -16'sd100
`define CODE_NUM_ARG -16'sd120
`define CODE_NONNUM_ARG -16'sd130
`define CODE_EXEC -16'sd200
`define CODE_RANGE -16'sd212
`define CODE_OVERFLOW -16'sd350
`define CODE_QUERY -16'sd400
`define CODE_TEST_CH1 16'sd300
`define CODE_TEST_CH2_ADD 16'sd100

`define QUEUE_DEPTH 10

`define INT_QUEUE_EVENT 0
`define INT_OVERFLOW 1
`define INT_TEST_FAIL 2

`endif

/* File: dv/remote_ctl_model.sv */
// remote controller model: raises one error event at a time
// assumes events are one-cycle pulses taken at a rising edge
`timescale 1ns/10ps
`default_nettype none
module remote_ctl_model (
  input wire logic i_clk,
  output logic [6:0] o_err,
  output logic [15:0] o_dev_code
);
  initial begin
    o_err = 7'h0;
    o_dev_code = 16'h0;
  end
  // the code is scrambled after the pulse so a late sample cannot pass
  task automatic pulse(input int k, input logic [15:0] c);
    @(posedge i_clk);
    o_err <= 7'h1 << k;
    o_dev_code <= c;
    @(posedge i_clk);
    o_err <= 7'h0;
    o_dev_code <= ~c;
  endtask
endmodule
`default_nettype wire

/* File: dv/error_logger_asserts.sv */
// bus handshake checks for the error logger
// assumes binding into the logger; sees its ports only
`timescale 1ns/10ps
`default_nettype none
module error_logger_checker (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_awvalid,
  input wire logic i_wvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic i_rready,
  input wire logic o_awready,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic [1:0] o_bresp,
  input wire logic [1:0] o_rresp,
  input wire logic [31:0] o_rdata
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  property p_bhold; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid not held");
  property p_rhold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("rvalid not held");
  property p_rans; i_arvalid && o_arready |=> o_rvalid; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_arblk; o_rvalid |-> !o_arready; endproperty
  a_arblk: assert property (p_arblk) else $error("read taken while busy");
  property p_awtake; i_awvalid && o_awready |=> !o_awready [*2]; endproperty
  a_awtake: assert property (p_awtake) else $error("awready back too soon");
  property p_wtake; i_wvalid && o_wready |=> !o_wready; endproperty
  a_wtake: assert property (p_wtake) else $error("wready back too soon");
  property p_bwin; $rose(o_bvalid) |-> !o_awready && !o_wready; endproperty
  a_bwin: assert property (p_bwin) else $error("ready during response");
  property p_rzero; o_rvalid && o_rresp == 2'h2 |-> o_rdata == 32'h0; endproperty
  a_rzero: assert property (p_rzero) else $error("error read not zero");
endmodule
bind error_queue_status_logger error_logger_checker chk_u (.*);
`default_nettype wire

/* File: dv/tb_top.sv */
// bench for the error logger: bus tasks, event pulses, self-test codes
// assumes remote_ctl_model for events and the checker bound to uut
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic i_clk = 1'h0;
  logic i_reset_n = 1'h0;
  logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0, i_arvalid = 1'h0;
  logic i_rready = 1'h0, i_test_done = 1'h0;
  logic [5:0] i_awaddr = 6'h0, i_araddr = 6'h0;
  logic [31:0] i_wdata = 32'h0, d;
  logic [3:0] i_wstrb = 4'hf;
  logic [13:0] i_ch1_fail = 14'h0, i_ch2_fail = 14'h0;
  logic [6:0] err;
  logic [15:0] i_dev_code;
  logic [1:0] r;
  wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
  wire [1:0] o_bresp, o_rresp;
  wire [31:0] o_rdata;
  int fail_count = 0;
  int checks = 0;
  int k;
  // order: command, numeric, non-numeric, execution, range, query, device
  logic [15:0] cd [7] = '{16'hff9c, 16'hff88, 16'hff7e, 16'hff38, 16'hff2c, 16'hfe70, 16'h65};
  int eb [7] = '{5, 5, 5, 4, 4, 2, 3};
  remote_ctl_model ctl (.i_clk(i_clk), .o_err(err), .o_dev_code(i_dev_code));
  error_queue_status_logger uut (.*, .i_cmd_invalid(err[0]), .i_num_arg_bad(err[1]),
    .i_nonnum_arg_bad(err[2]), .i_exec_fail(err[3]), .i_range_bad(err[4]),
    .i_query_fault(err[5]), .i_dev_error(err[6]));
  initial forever #50 i_clk = ~i_clk;
  task automatic chk(input string n, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask
  // one transfer; each valid is held until its own ready is sampled
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] v);
    @(posedge i_clk);
    {i_awaddr, i_araddr, i_wdata} <= {a, a, v};
    {i_awvalid, i_wvalid, i_bready} <= {3{w}};
    {i_arvalid, i_rready} <= {2{!w}};
    do begin
      @(posedge i_clk);
      if (o_awready) i_awvalid <= 1'h0;
      if (o_wready) i_wvalid <= 1'h0;
      if (o_arready) i_arvalid <= 1'h0;
      if (o_bvalid) {r, i_bready} <= {o_bresp, 1'h0};
      if (o_rvalid) {d, r, i_rready} <= {o_rdata, o_rresp, 1'h0};
    end while (i_awvalid || i_wvalid || i_bready || i_arvalid || i_rready);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    @(posedge i_clk);
    chk($sformatf("reg%h", a), d, e);
  endtask
  task automatic st(input logic [13:0] a, b, input logic [31:0] e);
    @(posedge i_clk);
    {i_ch1_fail, i_ch2_fail, i_test_done} <= {a, b, 1'h1};
    @(posedge i_clk);
    i_test_done <= 1'h0;
    rdc(6'h14, e);
  endtask
  task close_out;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'h1;
    rdc(6'h08, 32'h0);
    bus(1'h1, 6'h10, 32'h1);
    ctl.pulse(0, 16'h0);
    repeat (2) @(posedge i_clk);
    chk("irq", o_irq, 32'h1);
    bus(1'h1, 6'h10, 32'h0);
    repeat (2) @(posedge i_clk);
    chk("irq masked", o_irq, 32'h0);
    bus(1'h1, 6'h0c, 32'h7);
    bus(1'h1, 6'h10, 32'h1);
    repeat (2) @(posedge i_clk);
    chk("irq cleared", o_irq, 32'h0);
    rdc(6'h04, 32'hffffff9c);
    rdc(6'h04, 32'h0);
    bus(1'h1, 6'h00, 32'hff);
    $display("test irq done");
    for (k = 0; k < 7; k++) begin
      ctl.pulse(k, cd[6]);
      rdc(6'h00, 32'h1 << eb[k]);
      rdc(6'h04, {{16{cd[k][15]}}, cd[k]});
      bus(1'h1, 6'h00, 32'hff);
    end
    $display("test codes done");
    for (k = 1; k < 12; k++) ctl.pulse(6, 16'(k));
    rdc(6'h08, 32'ha);
    rdc(6'h0c, 32'h3);
    for (k = 1; k < 10; k++) rdc(6'h04, k);
    rdc(6'h04, 32'hfffffea2);
    $display("test overflow done");
    st(14'h0100, 14'h0001, 32'd308);
    st(14'h0000, 14'h2000, 32'd413);
    st(14'h0008, 14'h0000, 32'd303);
    st(14'h0000, 14'h0000, 32'h0);
    rdc(6'h0c, 32'h7);
    bus(1'h0, 6'h18, 32'h0);
    chk("rresp", r, 32'h2);
    bus(1'h1, 6'h08, 32'h5);
    chk("bresp", r, 32'h2);
    $display("test selftest and bus done");
    close_out;
  end
  initial begin
    repeat (6000) @(posedge i_clk);
    fail_count++;
    close_out;
  end
endmodule
`default_nettype wire
